// ===== rtl/sampling_pkg.sv
// Purpose: shared constants and types for the precise sampling block
// Assumes: 32-bit AXI4-Lite register bus, 12-bit byte address
// Notes: per-counter registers sit in a strided window above the base set
package sampling_pkg;
  localparam int NUM_CTR = 18;
  localparam int SAMPLE_CTR = 4;
  localparam int REC_WORDS = 10;
  localparam logic [31:0] REC_BYTES = 32'h0000_0028;
  localparam logic [3:0] REC_LAST = 4'h9;
  // base register byte offsets
  localparam logic [11:0] A_FEATURE = 12'h000;
  localparam logic [11:0] A_MISC = 12'h004;
  localparam logic [11:0] A_ENABLE = 12'h008;
  localparam logic [11:0] A_SAVE_PTR = 12'h00C;
  localparam logic [11:0] A_BUF_BASE = 12'h010;
  localparam logic [11:0] A_BUF_INDEX = 12'h014;
  localparam logic [11:0] A_BUF_MAX = 12'h018;
  localparam logic [11:0] A_BUF_THRESH = 12'h01C;
  localparam logic [11:0] A_RELOAD = 12'h020;
  localparam logic [11:0] A_STAMP_LO = 12'h030;
  localparam logic [11:0] A_STAMP_HI = 12'h034;
  localparam logic [11:0] A_STATUS = 12'h038;
  // counter window: 0x100 + 8*n, +0 config, +4 value
  localparam logic [3:0] CTR_PAGE = 4'h1;
  localparam logic [4:0] CTR_COUNT = 5'd18;
  // bit positions
  localparam int FEATURE_DS_BIT = 21;
  localparam int MISC_ABSENT_BIT = 12;
  localparam int ENABLE_BIT = 24;
  localparam int ST_BUSY = 0;
  localparam int ST_SMM = 1;
  localparam int ST_FIRED = 2;
  localparam int ST_FULL = 3;
  // counter config layout
  localparam int CFG_W = 15;
  localparam int CF_EN = 0;
  localparam int CF_CMP = 1;
  localparam int CF_COMPL = 2;
  localparam int CF_THR = 3;
  localparam int CF_CLASS = 7;
  localparam int CF_TAG_EN = 10;
  localparam int CF_TAG = 11;
  // event selector classes
  localparam logic [2:0] CLS_NONE = 3'h0;
  localparam logic [2:0] CLS_EXEC = 3'h1;
  localparam logic [2:0] CLS_FRONT = 3'h2;
  localparam logic [2:0] CLS_REPLAY = 3'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_STORE = 2'b10
  } store_state_t;
endpackage

// ===== rtl/event_counter.sv
// Purpose: one performance counter with threshold comparison
// Assumes: event count per cycle arrives on the core clock
// Notes: write beats reload beats counting; overflow is a one-cycle pulse
`timescale 1ns/10ps
module event_counter
  import sampling_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic clear, // soft initialization
  input wire logic awake, // low in deep sleep
  input wire logic [CFG_W-1:0] cfg, // counter configuration
  input wire logic [3:0] events, // events seen this cycle
  input wire logic wr, // software write strobe
  input wire logic [31:0] wr_data, // software write value
  input wire logic reload, // load reload value
  input wire logic [31:0] reload_data, // reload value
  output logic [31:0] value, // current count
  output logic overflow // wrap pulse
);
  typedef struct packed {
    logic [31:0] val;
    logic ovf;
  } ctr_t;
  ctr_t q, d;
  logic [31:0] inc;
  logic [32:0] sum;
  logic met;

  always_comb begin
    d = q;
    inc = 32'h0000_0000;
    met = 1'b0;
    // a null selector leaves the counter dormant
    if (cfg[CF_EN] && cfg[CF_CLASS +: 3] != CLS_NONE && awake) begin
      if (cfg[CF_CMP]) begin
        // threshold 15 with complement holds every cycle
        met = cfg[CF_COMPL] ? (events <= cfg[CF_THR +: 4]) : (events > cfg[CF_THR +: 4]);
        inc = {31'h0000_0000, met};
      end else begin
        inc = {28'h000_0000, events};
      end
    end
    sum = {1'b0, q.val} + {1'b0, inc};
    d.val = sum[31:0];
    d.ovf = sum[32];
    if (reload) begin
      d.val = reload_data;
      d.ovf = 1'b0;
    end
    if (wr) begin
      d.val = wr_data;
      d.ovf = 1'b0;
    end
    if (clear) begin
      d = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign value = q.val;
  assign overflow = q.ovf;
endmodule // event_counter

// ===== rtl/precise_sampling.sv
// Purpose: precise sampling, debug store control, stamp counter, counter array
// Assumes: core-side inputs are on the same clock; memory port holds until ready
// Notes: buffer fields are shadow registers loaded by software
// Summary of operation
// - sampling overflow writes gprs, flags and ip as a record at the next slot
// - after a record the sampling counter reloads from the reload value and runs on
// - interrupt when buffer index reaches threshold, before the buffer is full
// - buffer never wraps; index never returns to base by itself
// - only execution, front-end and replay classes produce records
// - only counter 4 can trigger records
// - feature register reports debug store presence in bit 21
// - misc register holds a sampling-absent flag, read as clear
// - bit 24 of the enable register turns sampling on or off
// - writable save-area pointer; records use the buffer fields
// - sampling interrupt shares the line with other debug store sources
// - debug store unusable in management mode and disabled on entry
// - machine check disables; reset and soft init clear all state
// - real address mode does not disable the mechanism
// - stamp counter counts every clock outside deep sleep, wraps at 64 bits
// - compare set, threshold 15, complement set makes counting every cycle
// - eighteen counters, each able to count clocks
// - upstream selector tags uops only with tag enable, using its 4-bit tag
`timescale 1ns/10ps
module precise_sampling
  import sampling_pkg::*;
(
  input wire logic clock, // 20 MHz core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [11:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [11:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [NUM_CTR*4-1:0] events, // per-counter event counts
  input wire logic [255:0] gpr_state, // eight general registers
  input wire logic [31:0] flags_state, // flags register
  input wire logic [31:0] ip_state, // instruction pointer
  input wire logic deep_sleep, // core in deep sleep
  input wire logic smm_entry, // pulse on management mode entry
  input wire logic in_smm, // core in management mode
  input wire logic machine_check, // pulse on machine check
  input wire logic soft_init, // pulse on soft initialization
  input wire logic other_ds_irq, // pulse from branch store or non-precise sampling
  output logic ds_irq, // shared debug store interrupt pulse
  output logic [3:0] uop_tag, // tag applied to upstream uops
  output logic mem_valid, // record word valid
  output logic [31:0] mem_addr, // record word address
  output logic [31:0] mem_data, // record word
  input wire logic mem_ready // memory took the word
);
  typedef struct packed {
    store_state_t state;
    logic aw_ok;
    logic [11:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en;
    logic [31:0] save_ptr;
    logic [31:0] base;
    logic [31:0] index;
    logic [31:0] max;
    logic [31:0] thresh;
    logic [31:0] reload;
    logic [NUM_CTR-1:0][CFG_W-1:0] cfg;
    logic [63:0] stamp;
    logic fired;
    logic irq;
    logic [3:0] tag;
    logic [REC_WORDS-1:0][31:0] rec;
    logic [3:0] wcnt;
    logic mem_valid;
    logic [31:0] mem_addr;
    logic [31:0] mem_data;
  } regs_t;
  localparam regs_t REGS_RESET = '{state: S_IDLE, default: '0};

  regs_t q, n;
  logic [NUM_CTR-1:0][31:0] cnt_val;
  logic [NUM_CTR-1:0] cnt_ovf;
  logic [NUM_CTR-1:0] cnt_wr;
  logic [31:0] cnt_data;
  logic cnt_reload;
  logic rd_hit, wr_hit;
  logic [31:0] rd_data;
  logic [31:0] old_data;
  logic [31:0] mask;
  logic [2:0] cls;
  logic trigger;

  // register read view of the current state
  function automatic logic [32:0] read_reg(input logic [11:0] a);
    logic [4:0] ci;
    logic [32:0] r;
    ci = a[7:3];
    r = {1'b1, 32'h0000_0000};
    case (a)
      A_FEATURE: r[FEATURE_DS_BIT] = 1'b1;
      A_MISC: r[MISC_ABSENT_BIT] = 1'b0;
      A_ENABLE: r[ENABLE_BIT] = q.en;
      A_SAVE_PTR: r[31:0] = q.save_ptr;
      A_BUF_BASE: r[31:0] = q.base;
      A_BUF_INDEX: r[31:0] = q.index;
      A_BUF_MAX: r[31:0] = q.max;
      A_BUF_THRESH: r[31:0] = q.thresh;
      A_RELOAD: r[31:0] = q.reload;
      A_STAMP_LO: r[31:0] = q.stamp[31:0];
      A_STAMP_HI: r[31:0] = q.stamp[63:32];
      A_STATUS: begin
        r[ST_BUSY] = (q.state == S_STORE);
        r[ST_SMM] = in_smm;
        r[ST_FIRED] = q.fired;
        r[ST_FULL] = (q.index >= q.max);
      end
      default: begin
        if (a[11:8] == CTR_PAGE && ci < CTR_COUNT && a[1:0] == 2'b00) begin
          r[31:0] = a[2] ? cnt_val[ci] : {17'h0_0000, q.cfg[ci]};
        end else begin
          r[32] = 1'b0;
        end
      end
    endcase
    return r;
  endfunction

  always_comb begin
    n = q;
    cnt_wr = '0;
    cnt_data = 32'h0000_0000;
    cnt_reload = 1'b0;
    {rd_hit, rd_data} = read_reg(araddr);
    {wr_hit, old_data} = read_reg(q.aw_addr);
    mask = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
    cls = q.cfg[SAMPLE_CTR][CF_CLASS +: 3];
    n.irq = 1'b0;

    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (awvalid && q.awready) begin
      n.aw_ok = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_ok = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end

    // stamp counter runs outside deep sleep and wraps
    if (!deep_sleep) begin
      n.stamp = q.stamp + 64'h0000_0000_0000_0001;
    end

    // record store engine
    trigger = cnt_ovf[SAMPLE_CTR] && q.en && !in_smm && q.state == S_IDLE;
    trigger = trigger && (cls == CLS_EXEC || cls == CLS_FRONT || cls == CLS_REPLAY);
    case (q.state)
      S_IDLE: begin
        // a full buffer drops the record rather than wrapping to base
        if (trigger && q.index < q.max) begin
          for (int i = 0; i < 8; i++) begin
            n.rec[i] = gpr_state[i*32 +: 32];
          end
          n.rec[8] = flags_state;
          n.rec[9] = ip_state;
          n.mem_addr = q.index; // index is the absolute address of the free slot
          n.mem_data = gpr_state[31:0];
          n.mem_valid = 1'b1;
          n.wcnt = 4'h0;
          n.state = S_STORE;
        end else if (trigger) begin
          cnt_reload = 1'b1;
        end
      end
      S_STORE: begin
        if (mem_ready) begin
          if (q.wcnt == REC_LAST) begin
            n.mem_valid = 1'b0;
            n.index = q.index + REC_BYTES;
            cnt_reload = 1'b1;
            n.state = S_IDLE;
          end else begin
            n.wcnt = q.wcnt + 4'h1;
            n.mem_addr = q.mem_addr + 32'h0000_0004;
            n.mem_data = q.rec[q.wcnt + 4'h1];
          end
        end
      end
      default: begin
        n.state = S_IDLE;
        n.mem_valid = 1'b0;
      end
    endcase

    // register write once address and data are both held
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      old_data = (old_data & ~mask) | (q.w_data & mask);
      case (q.aw_addr)
        A_ENABLE: n.en = old_data[ENABLE_BIT];
        A_SAVE_PTR: n.save_ptr = old_data;
        A_BUF_BASE: n.base = old_data;
        A_BUF_INDEX: n.index = old_data;
        A_BUF_MAX: n.max = old_data;
        A_BUF_THRESH: n.thresh = old_data;
        A_RELOAD: n.reload = old_data;
        default: begin
          if (q.aw_addr[11:8] == CTR_PAGE && q.aw_addr[7:3] < CTR_COUNT) begin
            if (q.aw_addr[2]) begin
              cnt_wr[q.aw_addr[7:3]] = 1'b1;
              cnt_data = old_data;
            end else begin
              n.cfg[q.aw_addr[7:3]] = old_data[CFG_W-1:0];
            end
          end
        end
      endcase
    end

    // threshold crossing: one pulse, re-armed below threshold
    if (!q.fired && n.index >= n.thresh && n.thresh != 32'h0000_0000) begin
      n.fired = 1'b1;
      n.irq = 1'b1;
    end else if (q.fired && n.index < n.thresh) begin
      n.fired = 1'b0;
    end
    if (other_ds_irq) begin
      n.irq = 1'b1;
    end

    // tags from any upstream selector with tag enable set
    n.tag = 4'h0;
    for (int i = 0; i < NUM_CTR; i++) begin
      if (q.cfg[i][CF_TAG_EN]) begin
        n.tag = n.tag | q.cfg[i][CF_TAG +: 4];
      end
    end

    // hardware disable beats a same-cycle software enable
    if (smm_entry || machine_check) begin
      n.en = 1'b0;
    end

    if (rvalid == 1'b0 && arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_data;
      n.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    n.awready = !n.aw_ok && !n.bvalid;
    n.wready = !n.w_ok && !n.bvalid;
    n.arready = !n.rvalid;

    if (soft_init) begin
      n = REGS_RESET;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= REGS_RESET;
    end else begin
      q <= n;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CTR; g++) begin : g_ctr
      event_counter u_ctr (
        .clock(clock),
        .rst_n(rst_n),
        .clear(soft_init),
        .awake(!deep_sleep),
        .cfg(q.cfg[g]),
        .events(events[g*4 +: 4]),
        .wr(cnt_wr[g]),
        .wr_data(cnt_data),
        .reload(g == SAMPLE_CTR && cnt_reload),
        .reload_data(q.reload),
        .value(cnt_val[g]),
        .overflow(cnt_ovf[g])
      );
    end
  endgenerate

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign ds_irq = q.irq;
  assign uop_tag = q.tag;
  assign mem_valid = q.mem_valid;
  assign mem_addr = q.mem_addr;
  assign mem_data = q.mem_data;
endmodule // precise_sampling

// ===== verification/sampling_monitor.sv
// Purpose: port checker for precise sampling records and interrupts
// Assumes: single core clock domain
// Notes: record beats are counted in helper logic
`timescale 1ns/10ps
module sampling_monitor
  import sampling_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic rst_n, // reset
  input wire logic mem_valid, // word valid
  input wire logic mem_ready, // word taken
  input wire logic [31:0] mem_addr, // word address
  input wire logic [31:0] mem_data, // word
  input wire logic [255:0] gpr_state, // general regs
  input wire logic [31:0] flags_state, // flags
  input wire logic in_smm, // mgmt mode
  input wire logic soft_init, // soft init
  input wire logic other_ds_irq, // other source
  input wire logic ds_irq // shared irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [3:0] beat_q;
  logic [31:0] last_q;
  logic [31:0] gpr0;
  assign gpr0 = gpr_state[31:0];
  // soft init restarts both, as the index may return to zero then
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      beat_q <= 4'h0;
      last_q <= 32'h0;
    end else if (soft_init) begin
      beat_q <= 4'h0;
      last_q <= 32'h0;
    end else if (mem_valid && mem_ready) begin
      beat_q <= (beat_q == REC_LAST) ? 4'h0 : beat_q + 4'h1;
      last_q <= mem_addr;
    end
  end
  sequence s_start;
    $rose(mem_valid);
  endsequence
  sequence s_take;
    mem_valid && mem_ready;
  endsequence
  a_first_word:
    assert property (s_start |-> mem_data == $past(gpr0)) else $error("word 0 not gpr0");
  a_word_hold:
    assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr)
      && $stable(mem_data)) else $error("record word changed before taken");
  a_addr_step:
    assert property ((s_take ##0 beat_q != REC_LAST) |=> mem_valid
      && mem_addr == $past(mem_addr) + 32'h4) else $error("record word missing or misplaced");
  a_flags_word:
    assert property (mem_valid && beat_q == 4'h8 |-> mem_data == flags_state)
      else $error("word 8 not flags");
  a_record_end:
    assert property ((s_take ##0 beat_q == REC_LAST) |=> !mem_valid)
      else $error("record longer than ten words");
  a_no_wrap:
    assert property (s_start |-> mem_addr > last_q) else $error("record address went back");
  a_smm_gate:
    assert property (s_start |-> !$past(in_smm)) else $error("record in management mode");
  a_init_clear:
    assert property (soft_init |=> !mem_valid && !ds_irq) else $error("soft init left activity");
  a_shared_irq:
    assert property (other_ds_irq |-> ##[1:2] ds_irq) else $error("other source not forwarded");
  a_irq_pulse:
    assert property (ds_irq |=> !ds_irq) else $error("irq longer than one cycle");
endmodule // sampling_monitor

bind precise_sampling sampling_monitor mon_u (.clock(clock), .rst_n(rst_n),
  .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_data(mem_data),
  .gpr_state(gpr_state), .flags_state(flags_state), .in_smm(in_smm), .soft_init(soft_init),
  .other_ds_irq(other_ds_irq), .ds_irq(ds_irq));

// ===== verification/record_memory.sv
// Purpose: memory holding the record buffer
// Assumes: word index taken relative to the buffer base
// Notes: 64 words only, enough for a few records
`timescale 1ns/10ps
module record_memory
  import sampling_pkg::*;
#(parameter logic [31:0] BASE = 32'h0000_1000)
(
  input wire logic clock, // core clock
  input wire logic rst_n, // reset
  input wire logic mem_valid, // word valid
  input wire logic [31:0] mem_addr, // word address
  input wire logic [31:0] mem_data, // word
  output logic mem_ready, // word taken
  output logic [7:0] n_words // words stored
);
  logic [31:0] words [0:63];
  logic [5:0] idx;
  assign idx = 6'((mem_addr - BASE) >> 2);
  // ready alternates so words meet both a prompt and a late answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_ready <= 1'b0;
      n_words <= 8'h00;
    end else begin
      mem_ready <= ~mem_ready;
      if (mem_valid && mem_ready) begin
        words[idx] <= mem_data;
        n_words <= n_words + 8'h01;
      end
    end
  end
endmodule // record_memory

// ===== verification/tb_top.sv
// Purpose: register-level tests of precise sampling
// Assumes: AXI4-Lite master tasks, 20 MHz clock
// Notes: record port answered by record_memory
`timescale 1ns/10ps
module tb_top
  import sampling_pkg::*;
;
  localparam logic [31:0] BASE = 32'h0000_1000;
  localparam logic [31:0] GPR0 = 32'hC0DE_0000;
  localparam int SLEEP_N = 37;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [NUM_CTR*4-1:0] events = '0;
  logic [255:0] gpr_state;
  logic [31:0] flags_state = 32'h0000_0246;
  logic [31:0] ip_state = 32'h0040_1000;
  logic deep_sleep = 1'b0, smm_entry = 1'b0, machine_check = 1'b0;
  logic soft_init = 1'b0, other_ds_irq = 1'b0, in_smm = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ds_irq, mem_valid, mem_ready;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, mem_addr, mem_data, rdv, s0;
  logic [3:0] uop_tag;
  logic [7:0] n_words;
  int failures = 0, n_checks = 0, irq_n = 0, cyc = 0;
  always #25 clock = ~clock;
  precise_sampling dut_u (.clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .events(events), .gpr_state(gpr_state), .flags_state(flags_state), .ip_state(ip_state),
    .deep_sleep(deep_sleep), .smm_entry(smm_entry), .in_smm(in_smm),
    .machine_check(machine_check), .soft_init(soft_init), .other_ds_irq(other_ds_irq),
    .ds_irq(ds_irq), .uop_tag(uop_tag), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_ready(mem_ready));
  record_memory #(.BASE(BASE)) mem_u (.clock(clock), .rst_n(rst_n), .mem_valid(mem_valid),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_ready(mem_ready), .n_words(n_words));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (ds_irq === 1'b1) begin
      irq_n++;
    end
    // whole sequence needs a few hundred cycles
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge clock);
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clock); while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (rvalid !== 1'b1);
    rdv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  initial begin
    for (int i = 0; i < 8; i++) begin
      gpr_state[32*i +: 32] <= GPR0 + 32'(i);
    end
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    events[19:16] <= 4'h1;
    events[27:24] <= 4'h1;
    rd(A_FEATURE);
    chk("feature flag", {31'h0, rdv[FEATURE_DS_BIT]}, 32'h1);
    rd(A_MISC);
    chk("absent flag", {31'h0, rdv[MISC_ABSENT_BIT]}, 32'h0);
    rd(12'h080);
    chk("unmapped read", {30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(12'h080, 32'h1);
    chk("unmapped write", {30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(12'h128, 32'h0000_5400);
    repeat (2) @(posedge clock);
    chk("tag enabled", {28'h0, uop_tag}, 32'hA);
    wr(12'h128, 32'h0000_1000);
    repeat (2) @(posedge clock);
    chk("tag disabled", {28'h0, uop_tag}, 32'h0);
    // buffer fields first, then enable, then the counter
    wr(A_SAVE_PTR, 32'h0000_2000);
    rd(A_SAVE_PTR);
    chk("save pointer", rdv, 32'h0000_2000);
    wr(A_BUF_BASE, BASE);
    wr(A_BUF_INDEX, BASE);
    wr(A_BUF_MAX, BASE + REC_BYTES * 32'h3);
    wr(A_BUF_THRESH, BASE + REC_BYTES * 32'h2);
    wr(A_RELOAD, 32'h0);
    wr(A_ENABLE, 32'h0100_0000);
    rd(A_ENABLE);
    chk("enable set", rdv, 32'h0100_0000);
    // counter 6 overflows too but must never store
    wr(12'h134, 32'hFFFF_FFFC);
    wr(12'h130, 32'h0000_0081);
    // a class outside the three overflows but stores nothing
    wr(12'h120, 32'h0000_0201);
    wr(12'h124, 32'hFFFF_FFFE);
    repeat (20) @(posedge clock);
    chk("class gate", {24'h0, n_words}, 32'h0);
    for (int c = 1; c <= 3; c++) begin
      // class first, so the overflow meets the class under test
      wr(12'h120, 32'(1 + (c << 7)));
      wr(12'h124, 32'hFFFF_FFFE);
      while (n_words < 8'(10 * c)) @(posedge clock);
      repeat (3) @(posedge clock);
      rd(A_BUF_INDEX);
      chk("index step", rdv, BASE + REC_BYTES * 32'(c));
      rd(12'h124);
      chk("reloaded", {31'h0, rdv < 32'h40}, 32'h1);
      chk("gpr word", mem_u.words[10*c-10], GPR0);
      chk("gpr7 word", mem_u.words[10*c-3], GPR0 + 32'h7);
      chk("ip word", mem_u.words[10*c-1], ip_state);
    end
    wr(12'h124, 32'hFFFF_FFFE);
    repeat (20) @(posedge clock);
    chk("words at max", {24'h0, n_words}, 32'd30);
    rd(A_BUF_INDEX);
    chk("index kept", rdv, BASE + REC_BYTES * 32'h3);
    chk("threshold irq", irq_n, 32'h1);
    other_ds_irq <= 1'b1;
    @(posedge clock);
    other_ds_irq <= 1'b0;
    repeat (4) @(posedge clock);
    chk("shared irq", irq_n, 32'h2);
    deep_sleep <= 1'b1;
    wr(12'h104, 32'h0);
    wr(12'h100, 32'h0000_00FF);
    rd(A_STAMP_LO);
    s0 = rdv;
    deep_sleep <= 1'b0;
    repeat (SLEEP_N) @(posedge clock);
    deep_sleep <= 1'b1;
    rd(12'h104);
    chk("clock count", rdv, 32'(SLEEP_N));
    rd(A_STAMP_LO);
    chk("stamp delta", rdv - s0, 32'(SLEEP_N));
    // counters must run here, or the gate below is never tried
    deep_sleep <= 1'b0;
    in_smm <= 1'b1;
    wr(A_BUF_INDEX, BASE);
    rd(A_STATUS);
    chk("status", {28'h0, rdv[3:0]}, 32'h2);
    wr(12'h124, 32'hFFFF_FFFE);
    repeat (20) @(posedge clock);
    chk("smm gate", {24'h0, n_words}, 32'd30);
    in_smm <= 1'b0;
    smm_entry <= 1'b1;
    @(posedge clock);
    smm_entry <= 1'b0;
    rd(A_ENABLE);
    chk("smm disable", rdv, 32'h0);
    wr(A_ENABLE, 32'h0100_0000);
    machine_check <= 1'b1;
    @(posedge clock);
    machine_check <= 1'b0;
    rd(A_ENABLE);
    chk("mc disable", rdv, 32'h0);
    soft_init <= 1'b1;
    @(posedge clock);
    soft_init <= 1'b0;
    repeat (3) @(posedge clock);
    rd(A_BUF_INDEX);
    chk("init clear", rdv, 32'h0);
    report_and_stop();
  end
endmodule // tb_top
